// File: src/flash_erase_suspend_control.sv
// Overview of operation
// - sector erase is six writes: unlock, unlock, config, unlock, unlock, erase
// - chip erase is six writes with chip erase command last
// - host waits 400us after erase resume before next erase suspend
// - after program suspend, resume before any further program
// - program resume only when suspended; host waits 5us before suspend
// - after erase failure host must write reset command
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fesc_regs.svh"

module flash_erase_suspend_control #(
  parameter int unsigned ERASE_GAP_CYC =
    `FESC_ERASE_GAP_US * `FESC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fesc_pkg::fesc_pins_s flash,
  input wire logic [15:0] dqIn,
  input wire logic readyBusyN
);

  localparam logic [13:0] PROG_GAP_CYC =
    14'(`FESC_PROG_GAP_US * `FESC_CLK_MHZ);
  localparam logic [13:0] ERASE_GAP = 14'(ERASE_GAP_CYC);
  localparam logic [3:0] WE_CYC =
    4'((`FESC_WE_PULSE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS);
  // read strobe stretched so the synchronised bus settles before capture
  localparam logic [3:0] RD_CYC =
    4'((`FESC_OE_PULSE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS
       + `FESC_SYNC_STAGES);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [16:0] syncA_r;
  logic [16:0] syncB_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 17'h1ffff;
      syncB_r <= 17'h1ffff;
    end else begin
      syncA_r <= {readyBusyN, dqIn};
      syncB_r <= syncA_r;
    end
  end

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  fesc_pkg::fesc_state_e state_r, state_nxt;
  fesc_pkg::fesc_op_e op_r, op_nxt;
  fesc_pkg::fesc_pins_s pins_nxt;
  fesc_pkg::fesc_cyc_s cyc;
  logic [2:0] idx_r, idx_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [13:0] eraseGap_r, progGap_r;
  logic [15:0] rdData_r;
  logic [20:0] addr_r;
  logic holdReset_r, refused_r, eraseSusp_r, progSusp_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitCtrl = paddr == `FESC_OFS_CTRL;
  wire hitAddr = paddr == `FESC_OFS_ADDR;
  wire hitCmd = paddr == `FESC_OFS_CMD;
  wire hitStat = paddr == `FESC_OFS_STATUS;
  wire hitRdata = paddr == `FESC_OFS_RDATA;
  wire mapped = hitCtrl | hitAddr | hitCmd | hitStat | hitRdata;
  wire wrEn = accessPh & pwrite & mapped;
  wire cmdWr = wrEn & hitCmd;
  wire clrRefused = wrEn & hitStat & pwdata[`FESC_STAT_REFUSED];
  wire [2:0] reqOp = pwdata[2:0];
  wire reqErase = reqOp == fesc_pkg::OP_SECTOR || reqOp == fesc_pkg::OP_CHIP;
  wire badOp = (reqOp == fesc_pkg::OP_PSUS && progSusp_r)
    | (reqOp == fesc_pkg::OP_PRES && !progSusp_r)
    | (reqOp == fesc_pkg::OP_ERES && !eraseSusp_r)
    | (reqErase && eraseSusp_r);
  wire accept = cmdWr & (state_r == fesc_pkg::S_IDLE) & ~holdReset_r & ~badOp;
  wire busy = state_r != fesc_pkg::S_IDLE;
  wire isErase = op_r == fesc_pkg::OP_SECTOR || op_r == fesc_pkg::OP_CHIP;
  wire [2:0] lastIdx = isErase ? `FESC_SEQ_LAST_ERASE : `FESC_SEQ_LAST_ONE;
  wire needGap = (op_r == fesc_pkg::OP_ESUS && eraseGap_r != 14'h0000)
    | (op_r == fesc_pkg::OP_PSUS && progGap_r != 14'h0000);
  wire seqDone = state_r == fesc_pkg::S_WREC && idx_r == lastIdx;

  wire [31:0] statWord = {26'h0000000, progSusp_r, eraseSusp_r,
    state_r == fesc_pkg::S_GAP, refused_r, syncB_r[16], busy};
  wire [31:0] rdMux = hitCtrl ? {31'h00000000, holdReset_r}
    : hitAddr ? {11'h000, addr_r}
    : hitStat ? statWord
    : hitRdata ? {16'h0000, rdData_r} : 32'h00000000;

  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // -------------------------------------------------------------
  // bus cycle word for the current step of the sequence
  // -------------------------------------------------------------
  function automatic fesc_pkg::fesc_cyc_s seqWord(
    input fesc_pkg::fesc_op_e op,
    input logic [2:0] idx,
    input logic [20:0] tgt
  );
    fesc_pkg::fesc_cyc_s w;
    w.addr = `FESC_UNLOCK_ADDR1;
    w.data = `FESC_UNLOCK_DATA1;
    case (op)
      fesc_pkg::OP_SECTOR, fesc_pkg::OP_CHIP: begin
        case (idx)
          3'h1, 3'h4: begin
            w.addr = `FESC_UNLOCK_ADDR2;
            w.data = `FESC_UNLOCK_DATA2;
          end
          3'h2: w.data = `FESC_CFG_DATA;
          3'h5: begin
            if (op == fesc_pkg::OP_SECTOR) begin
              w.addr = tgt;
              w.data = `FESC_SECTOR_ERASE_DATA;
            end else begin
              w.data = `FESC_CHIP_ERASE_DATA;
            end
          end
          default: w.data = `FESC_UNLOCK_DATA1;
        endcase
      end
      fesc_pkg::OP_ESUS: w.data = `FESC_ERASE_SUSPEND_DATA;
      fesc_pkg::OP_ERES: w.data = `FESC_ERASE_RESUME_DATA;
      fesc_pkg::OP_PSUS: w.data = `FESC_PROG_SUSPEND_DATA;
      fesc_pkg::OP_PRES: w.data = `FESC_PROG_RESUME_DATA;
      fesc_pkg::OP_RST: w.data = `FESC_RESET_DATA;
      default: w.addr = tgt;
    endcase
    if (op != fesc_pkg::OP_SECTOR && op != fesc_pkg::OP_CHIP) begin
      w.addr = tgt;
    end
    return w;
  endfunction

  assign cyc = seqWord(op_r, idx_nxt, addr_r);

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    case (state_r)
      fesc_pkg::S_IDLE: begin
        if (accept) begin
          op_nxt = fesc_pkg::fesc_op_e'(reqOp);
          idx_nxt = 3'h0;
          state_nxt = fesc_pkg::S_GAP;
        end
      end
      fesc_pkg::S_GAP: begin
        if (!needGap) begin
          if (op_r == fesc_pkg::OP_POLL) begin
            cnt_nxt = RD_CYC;
            state_nxt = fesc_pkg::S_RLOW;
          end else begin
            state_nxt = fesc_pkg::S_WSET;
          end
        end
      end
      fesc_pkg::S_WSET: begin
        cnt_nxt = WE_CYC;
        state_nxt = fesc_pkg::S_WLOW;
      end
      fesc_pkg::S_WLOW: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = fesc_pkg::S_WREC;
        end
      end
      fesc_pkg::S_WREC: begin
        if (idx_r == lastIdx) begin
          state_nxt = fesc_pkg::S_IDLE;
        end else begin
          idx_nxt = idx_r + 3'h1;
          state_nxt = fesc_pkg::S_WSET;
        end
      end
      fesc_pkg::S_RLOW: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = fesc_pkg::S_IDLE;
        end
      end
      default: state_nxt = fesc_pkg::S_IDLE;
    endcase
  end

  // strobes are registered so the pins never glitch between states
  always_comb begin
    pins_nxt = flash;
    pins_nxt.resetN = ~holdReset_r;
    pins_nxt.ceN = state_nxt == fesc_pkg::S_IDLE || state_nxt == fesc_pkg::S_GAP;
    pins_nxt.oeN = state_nxt != fesc_pkg::S_RLOW;
    pins_nxt.weN = state_nxt != fesc_pkg::S_WLOW;
    pins_nxt.dqOe = state_nxt == fesc_pkg::S_WSET
      || state_nxt == fesc_pkg::S_WLOW || state_nxt == fesc_pkg::S_WREC;
    if (state_nxt == fesc_pkg::S_WSET && state_r != fesc_pkg::S_WSET) begin
      pins_nxt.addr = cyc.addr;
      pins_nxt.dqOut = cyc.data;
    end else if (state_nxt == fesc_pkg::S_RLOW && state_r == fesc_pkg::S_GAP) begin
      pins_nxt.addr = addr_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= fesc_pkg::S_IDLE;
      op_r <= fesc_pkg::OP_POLL;
      idx_r <= 3'h0;
      cnt_r <= 4'h0;
      flash <= '{addr: 21'h000000, dqOut: 16'h0000, dqOe: 1'b0,
        ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b1};
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      flash <= pins_nxt;
    end
  end

  // -------------------------------------------------------------
  // spacing timers and suspend bookkeeping
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eraseGap_r <= 14'h0000;
      progGap_r <= 14'h0000;
      eraseSusp_r <= 1'b0;
      progSusp_r <= 1'b0;
    end else begin
      if (seqDone && op_r == fesc_pkg::OP_ERES) begin
        eraseGap_r <= ERASE_GAP;
      end else if (eraseGap_r != 14'h0000) begin
        eraseGap_r <= eraseGap_r - 14'h0001;
      end
      if (seqDone && op_r == fesc_pkg::OP_PRES) begin
        progGap_r <= PROG_GAP_CYC;
      end else if (progGap_r != 14'h0000) begin
        progGap_r <= progGap_r - 14'h0001;
      end
      // a hardware or command reset drops both suspended states
      if (holdReset_r || (seqDone && op_r == fesc_pkg::OP_RST)) begin
        eraseSusp_r <= 1'b0;
        progSusp_r <= 1'b0;
      end else if (seqDone) begin
        if (op_r == fesc_pkg::OP_ESUS) eraseSusp_r <= 1'b1;
        if (op_r == fesc_pkg::OP_ERES) eraseSusp_r <= 1'b0;
        if (op_r == fesc_pkg::OP_PSUS) progSusp_r <= 1'b1;
        if (op_r == fesc_pkg::OP_PRES) progSusp_r <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdReset_r <= 1'b0;
      addr_r <= 21'h000000;
      refused_r <= 1'b0;
      rdData_r <= 16'h0000;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      if (wrEn && hitCtrl) holdReset_r <= pwdata[`FESC_CTRL_HOLD_RST];
      if (wrEn && hitAddr) addr_r <= pwdata[20:0];
      // a refusal in the same cycle as its clear is kept
      if (cmdWr && !accept) refused_r <= 1'b1;
      else if (clrRefused) refused_r <= 1'b0;
      if (state_r == fesc_pkg::S_RLOW && cnt_r == 4'h1) rdData_r <= syncB_r[15:0];
      if (setupPh) begin
        prdata_r <= pwrite ? 32'h00000000 : rdMux;
        pslverr_r <= ~mapped;
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  logic [2:0] weCount_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) weCount_r <= 3'h0;
    else if (accept) weCount_r <= 3'h0;
    else if (state_r == fesc_pkg::S_WLOW && state_nxt == fesc_pkg::S_WREC)
      weCount_r <= weCount_r + 3'h1;
  end

  a_erase_six_writes: assert property (@(posedge clk) disable iff (!rst_n)
    (seqDone && op_r == fesc_pkg::OP_SECTOR) |-> weCount_r == 3'h6
      && flash.dqOut == `FESC_SECTOR_ERASE_DATA && flash.addr == addr_r)
    else $error("sector erase not six writes ending in erase command");
  a_chip_six_writes: assert property (@(posedge clk) disable iff (!rst_n)
    (seqDone && op_r == fesc_pkg::OP_CHIP) |-> weCount_r == 3'h6
      && flash.dqOut == `FESC_CHIP_ERASE_DATA)
    else $error("chip erase not six writes ending in chip command");
  a_erase_sus_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == fesc_pkg::S_WSET && op_r == fesc_pkg::OP_ESUS)
      |-> eraseGap_r == 14'h0000)
    else $error("erase suspend too soon after resume");
  a_resume_load_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (seqDone && op_r == fesc_pkg::OP_ERES) |=> eraseGap_r == ERASE_GAP)
    else $error("erase gap timer not loaded");
  a_prog_sus_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == fesc_pkg::S_WSET && op_r == fesc_pkg::OP_PSUS)
      |-> progGap_r == 14'h0000)
    else $error("program suspend too soon after resume");
  a_prog_resume_only: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && reqOp == fesc_pkg::OP_PRES) |-> progSusp_r)
    else $error("program resume sent while not suspended");
  a_reset_cmd_word: assert property (@(posedge clk) disable iff (!rst_n)
    (!flash.weN && op_r == fesc_pkg::OP_RST) |-> flash.dqOut == `FESC_RESET_DATA)
    else $error("reset command word wrong");
  a_write_strobe_ok: assert property (@(posedge clk) disable iff (!rst_n)
    !flash.weN |-> !flash.ceN && flash.oeN && flash.dqOe ##1 flash.dqOe)
    else $error("write strobe without chip enable or data drive");
  a_read_strobe_len: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(flash.oeN) |-> (!flash.oeN && !flash.dqOe) [*5] ##1 flash.oeN)
    else $error("read strobe length wrong");

endmodule
`default_nettype wire

// File: src/fesc_regs.svh
`ifndef FESC_REGS_SVH
`define FESC_REGS_SVH

// -------------------------------------------------------------
// register map (byte offsets on the apb side)
// -------------------------------------------------------------
`define FESC_OFS_CTRL 8'h00
`define FESC_OFS_ADDR 8'h04
`define FESC_OFS_CMD 8'h08
`define FESC_OFS_STATUS 8'h0c
`define FESC_OFS_RDATA 8'h10

// ctrl and status fields
`define FESC_CTRL_HOLD_RST 0
`define FESC_STAT_BUSY 0
`define FESC_STAT_RDYBSY 1
`define FESC_STAT_REFUSED 2
`define FESC_STAT_GAPWAIT 3
`define FESC_STAT_ERSUSP 4
`define FESC_STAT_PGSUSP 5

// -------------------------------------------------------------
// flash command words, kept configurable
// -------------------------------------------------------------
`define FESC_UNLOCK_ADDR1 21'h000555
`define FESC_UNLOCK_ADDR2 21'h0002aa
`define FESC_UNLOCK_DATA1 16'h00aa
`define FESC_UNLOCK_DATA2 16'h0055
`define FESC_CFG_DATA 16'h0080
`define FESC_SECTOR_ERASE_DATA 16'h0030
`define FESC_CHIP_ERASE_DATA 16'h0010
`define FESC_ERASE_SUSPEND_DATA 16'h00b0
`define FESC_ERASE_RESUME_DATA 16'h0030
`define FESC_PROG_SUSPEND_DATA 16'h0051
`define FESC_PROG_RESUME_DATA 16'h0050
`define FESC_RESET_DATA 16'h00f0

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define FESC_CLK_MHZ 25
`define FESC_CLK_NS 40
`define FESC_ERASE_GAP_US 400
`define FESC_PROG_GAP_US 5
`define FESC_WE_PULSE_NS 80
`define FESC_OE_PULSE_NS 100
`define FESC_SYNC_STAGES 2
`define FESC_SEQ_LAST_ERASE 3'h5
`define FESC_SEQ_LAST_ONE 3'h0

`endif

// File: src/fesc_pkg.sv
package fesc_pkg;

  typedef enum logic [2:0] {
    OP_POLL = 3'b000,
    OP_SECTOR = 3'b001,
    OP_CHIP = 3'b010,
    OP_ESUS = 3'b011,
    OP_ERES = 3'b100,
    OP_PSUS = 3'b101,
    OP_PRES = 3'b110,
    OP_RST = 3'b111
  } fesc_op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_GAP = 3'b001,
    S_WSET = 3'b010,
    S_WLOW = 3'b011,
    S_WREC = 3'b100,
    S_RLOW = 3'b101
  } fesc_state_e;

  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] dqOut;
    logic dqOe;
    logic ceN;
    logic oeN;
    logic weN;
    logic resetN;
  } fesc_pins_s;

  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
  } fesc_cyc_s;

endpackage

// File: test/fesc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fesc_regs.svh"
// ---------------------------------------------------------
// flash device model: mode 0 read, 1 window, 2 erasing,
// 3 erase suspended, 4 chip erase
// ---------------------------------------------------------
module fesc_flash_model #(
  parameter logic [15:0] ARR = 16'h5a3c,
  parameter int WIN_NS = 4000,
  parameter int SUS_NS = 200
) (
  input wire fesc_pkg::fesc_pins_s flash,
  output logic [15:0] dqIn,
  output logic readyBusyN
);
  localparam logic [36:0] UNL [5] = '{
    {`FESC_UNLOCK_ADDR1, `FESC_UNLOCK_DATA1},
    {`FESC_UNLOCK_ADDR2, `FESC_UNLOCK_DATA2},
    {`FESC_UNLOCK_ADDR1, `FESC_CFG_DATA},
    {`FESC_UNLOCK_ADDR1, `FESC_UNLOCK_DATA1},
    {`FESC_UNLOCK_ADDR2, `FESC_UNLOCK_DATA2}};
  int mode = 0;
  int seq = 0;
  logic tog = 1'b0;
  logic lt = 1'b0;
  logic psusp = 1'b0;
  logic [8:0] sel = '0;
  logic [15:0] rd = '0;
  logic [15:0] d;
  time winEnd = 0;
  assign d = flash.dqOut;
  // data is latched on the rising write strobe
  always @(posedge flash.weN) if (!flash.ceN && flash.resetN) begin
    if (seq < 5 && {flash.addr, d} == UNL[seq]) seq++;
    else begin
      if (seq == 5) begin
        if (d == `FESC_SECTOR_ERASE_DATA && mode < 2) begin
          mode = 1;
          sel = flash.addr[20:12];
          winEnd = $time + WIN_NS;
        end else if (d == `FESC_CHIP_ERASE_DATA && mode == 0) mode = 4;
      end else if (d == `FESC_ERASE_SUSPEND_DATA && mode == 1) mode = 3;
      else if (mode == 1) mode = 0;
      else if (d == `FESC_ERASE_SUSPEND_DATA && mode == 2) begin
        fork
          #(SUS_NS) mode = 3;
        join_none
      end else if (d == `FESC_ERASE_RESUME_DATA && mode == 3) mode = 2;
      else if (d == `FESC_PROG_SUSPEND_DATA && mode inside {0, 3}) psusp = 1'b1;
      else if (d == `FESC_PROG_RESUME_DATA && psusp) psusp = 1'b0;
      else if (d == `FESC_RESET_DATA && mode inside {0, 3}) mode = 0;
      seq = 0;
    end
  end
  always #20 if (mode == 1 && $time >= winEnd) mode = 2;
  always @(negedge flash.resetN) begin
    mode = 0;
    seq = 0;
    psusp = 1'b0;
  end
  always @(negedge flash.oeN) if (!flash.ceN) begin
    if (mode inside {1, 2, 4}) tog = ~tog;
    if (mode == 4 || (mode != 0 && flash.addr[20:12] == sel)) lt = ~lt;
    if (mode == 0 || (mode == 3 && flash.addr[20:12] != sel)) rd = ARR;
    else if (mode == 3) rd = {8'h00, 1'b1, tog, 3'h0, lt, 2'h0};
    else rd = {8'h00, 1'b0, tog, 2'h0, mode == 2, lt, 2'h0};
  end
  // a released bus shows the inverse, never the last value
  assign dqIn = (!flash.oeN && !flash.ceN) ? rd : ~rd;
  assign readyBusyN = !(mode inside {1, 2, 4});
endmodule
`default_nettype wire

// File: test/flash_erase_suspend_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fesc_regs.svh"
`define CHK(g, e, m) begin \
  cmpCount++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("unexpected at %0t: %s", $time, m); \
  end \
end
// ---------------------------------------------------------
// apb driver, flash write watcher and read watcher
// ---------------------------------------------------------
module flash_erase_suspend_control_tb;
  localparam logic [15:0] ARR = 16'h5a3c;
  localparam logic [7:0] STA = `FESC_OFS_STATUS;
  localparam logic [7:0] CMD = `FESC_OFS_CMD;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic expOn = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] dqIn;
  logic readyBusyN;
  logic pr;
  logic [2:0] po;
  logic [31:0] rdv;
  logic [20:0] secA;
  logic [20:0] secB;
  logic [32:0] expQ [$];
  logic [36:0] expW [$];
  fesc_pkg::fesc_pins_s flash;
  int miscompares = 0;
  int cmpCount = 0;
  flash_erase_suspend_control #(.ERASE_GAP_CYC(60)) DUT (.clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .flash, .dqIn, .readyBusyN);
  fesc_flash_model #(.ARR(ARR)) flashDev (.flash, .dqIn, .readyBusyN);
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (psel && penable && pready && expOn)
    `CHK({pslverr, prdata}, expQ.pop_front(), "apb read")
  always @(posedge flash.weN) if (rst_n) begin
    if (expW.size() == 0) `CHK(1'b1, 1'b0, "stray write")
    else `CHK({flash.addr, flash.dqOut}, expW.pop_front(), "flash write")
  end
  task automatic giveVerdict;
    if (expW.size() != 0) `CHK(1'b1, 1'b0, "write missing")
    $display("compared %0d mismatched %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    `CHK(1'b1, 1'b0, "timeout")
    giveVerdict();
  end
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic c, input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expOn <= c;
    if (c) expQ.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    expOn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, '0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0, 1'b1, {1'b0, e});
  endtask
  task automatic cmd(input logic [2:0] op, input logic [20:0] a);
    int n;
    n = 0;
    wr(`FESC_OFS_ADDR, {11'h0, a});
    wr(CMD, {29'h0, op});
    do begin
      apb(1'b0, STA, '0, 1'b0, '0);
      n++;
    end while (rdv[`FESC_STAT_BUSY] !== 1'b0 && n < 100);
    // margin for the model's suspend delay and the ready synchroniser
    repeat (10) @(posedge clk);
  endtask
  task automatic poll(input logic [20:0] a, input logic [15:0] e);
    cmd(fesc_pkg::OP_POLL, a);
    rd(`FESC_OFS_RDATA, {16'h0, e});
  endtask
  task automatic pushSeq(input logic [36:0] last);
    expW.push_back({`FESC_UNLOCK_ADDR1, `FESC_UNLOCK_DATA1});
    expW.push_back({`FESC_UNLOCK_ADDR2, `FESC_UNLOCK_DATA2});
    expW.push_back({`FESC_UNLOCK_ADDR1, `FESC_CFG_DATA});
    expW.push_back({`FESC_UNLOCK_ADDR1, `FESC_UNLOCK_DATA1});
    expW.push_back({`FESC_UNLOCK_ADDR2, `FESC_UNLOCK_DATA2});
    expW.push_back(last);
  endtask
  initial begin
    void'($urandom(50565));
    secA = {9'h011, 12'($urandom)};
    secB = {9'h0a2, 12'($urandom)};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(STA, 32'h2);
    apb(1'b0, 8'h14, '0, 1'b1, {1'b1, 32'h0});
    wr(`FESC_OFS_ADDR, {11'h0, secB});
    rd(`FESC_OFS_ADDR, {11'h0, secB});
    poll(secA, ARR);
    pushSeq({secB, `FESC_SECTOR_ERASE_DATA});
    cmd(fesc_pkg::OP_SECTOR, secB);
    expW.push_back({secB, `FESC_RESET_DATA});
    cmd(fesc_pkg::OP_RST, secB);
    rd(STA, 32'h2);
    pushSeq({secA, `FESC_SECTOR_ERASE_DATA});
    cmd(fesc_pkg::OP_SECTOR, secA);
    poll(secA, 16'h0044);
    repeat (120) @(posedge clk);
    poll(secA, 16'h0008);
    poll(secB, 16'h0048);
    rd(STA, 32'h0);
    expW.push_back({secA, `FESC_ERASE_SUSPEND_DATA});
    cmd(fesc_pkg::OP_ESUS, secA);
    rd(STA, 32'h12);
    poll(secA, 16'h00c4);
    poll(secB, ARR);
    for (int i = 1; i < 3; i++) begin
      cmd(i[2:0], secB);
      rd(STA, 32'h16);
      wr(STA, 32'h4);
    end
    expW.push_back({secA, `FESC_ERASE_RESUME_DATA});
    cmd(fesc_pkg::OP_ERES, secA);
    expW.push_back({secA, `FESC_ERASE_SUSPEND_DATA});
    wr(CMD, {29'h0, fesc_pkg::OP_ESUS});
    rd(STA, 32'h9);
    // wait without touching ADDR: the held suspend still takes its address
    do apb(1'b0, STA, '0, 1'b0, '0);
    while (rdv[`FESC_STAT_BUSY] !== 1'b0);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      pr = (i == 0 || i == 2);
      po = (i == 1 || i == 2) ? fesc_pkg::OP_PSUS : fesc_pkg::OP_PRES;
      if (!pr && po == fesc_pkg::OP_PSUS)
        expW.push_back({secA, `FESC_PROG_SUSPEND_DATA});
      else if (!pr) expW.push_back({secA, `FESC_PROG_RESUME_DATA});
      cmd(po, secA);
      rd(STA, {26'h0, po == fesc_pkg::OP_PSUS, 2'b10, pr, 2'b10});
      if (pr) wr(STA, 32'h4);
    end
    expW.push_back({secA, `FESC_RESET_DATA});
    cmd(fesc_pkg::OP_RST, secA);
    rd(STA, 32'h2);
    pushSeq({`FESC_UNLOCK_ADDR1, `FESC_CHIP_ERASE_DATA});
    cmd(fesc_pkg::OP_CHIP, secA);
    rd(STA, 32'h0);
    poll(secA, 16'h0000);
    poll(secB, 16'h0044);
    wr(`FESC_OFS_CTRL, 32'h1);
    @(posedge clk);
    `CHK(flash.resetN, 1'b0, "reset pin")
    cmd(fesc_pkg::OP_SECTOR, secA);
    rd(STA, 32'h6);
    wr(`FESC_OFS_CTRL, 32'h0);
    rd(`FESC_OFS_CTRL, 32'h0);
    wr(STA, 32'h4);
    rd(STA, 32'h2);
    giveVerdict();
  end
endmodule
`default_nettype wire
